// ### fhwr_map.svh
// Function
// - long reset low restores registers within recovery
// - failed power-up makes reset run full power-up
// - software reset works in idle whatever the pin level
// - host holds reset high setup time first
// - reset aborts, floats outputs, ignores commands, standby
// - host raises select during recovery, holds after
// - host selects only after recovery time elapsed
// - boot autoread limits reset pulse maximum width
// - reset ignored in power-up; held reset blocks selection
// - host pulse plus hold covers recovery period
// - shared pin resets when quad off, or when deselected with reset enabled
// - with quad on, shared pin low ignored while select low and until select has been high FHWR_CS_CYC cycles
// - device drives io3 high before releasing it when select rises after a quad read
// - host drives io3 high before releasing it
// - with quad on, select low makes shared pin data io3
`ifndef FHWR_MAP_SVH
`define FHWR_MAP_SVH

`define FHWR_CLK_NS        20
`define FHWR_T_RP_MIN_NS   200
`define FHWR_T_RP_MAX_US   5
`define FHWR_T_RPH_US      35
`define FHWR_T_RS_NS       50
`define FHWR_T_RH_NS       50
`define FHWR_T_CS_NS       20
`define FHWR_T_DIS_NS      20
`define FHWR_T_PU_US       100

`define FHWR_RP_CYC     ((`FHWR_T_RP_MIN_NS + `FHWR_CLK_NS - 1) / `FHWR_CLK_NS)
`define FHWR_RP_MAX_CYC ((`FHWR_T_RP_MAX_US * 1000) / `FHWR_CLK_NS)
`define FHWR_RPH_CYC    ((`FHWR_T_RPH_US * 1000 + `FHWR_CLK_NS - 1) / `FHWR_CLK_NS)
`define FHWR_RS_CYC     ((`FHWR_T_RS_NS + `FHWR_CLK_NS - 1) / `FHWR_CLK_NS)
`define FHWR_RH_CYC     ((`FHWR_T_RH_NS + `FHWR_CLK_NS - 1) / `FHWR_CLK_NS)
`define FHWR_CS_CYC     ((`FHWR_T_CS_NS + `FHWR_CLK_NS - 1) / `FHWR_CLK_NS)
`define FHWR_DIS_CYC    ((`FHWR_T_DIS_NS < `FHWR_CLK_NS) ? 1 : (`FHWR_T_DIS_NS / `FHWR_CLK_NS))
`define FHWR_PU_CYC_DEF ((`FHWR_T_PU_US * 1000 + `FHWR_CLK_NS - 1) / `FHWR_CLK_NS)

`define FHWR_SYNC_CYC     2
`define FHWR_PULSE_MARGIN 3
`define FHWR_SCK_HALF_DEF 4

`endif

// ### fhwr_pkg.sv
`default_nettype none
package fhwr_pkg;
   typedef enum logic [2:0] {
      FHWR_D_POWERUP = 3'h0,
      FHWR_D_IDLE    = 3'h1,
      FHWR_D_WARM    = 3'h2,
      FHWR_D_FULLPOR = 3'h3,
      FHWR_D_HELD    = 3'h4,
      FHWR_D_HOLD    = 3'h5
   } fhwr_dev_state_e;

   typedef enum logic [1:0] {
      FHWR_H_IDLE  = 2'h0,
      FHWR_H_PULSE = 2'h1,
      FHWR_H_HOLD  = 2'h2,
      FHWR_H_SETUP = 2'h3
   } fhwr_host_state_e;

   typedef logic [15:0] fhwr_cnt_t;
endpackage
`default_nettype wire

// ### fhwr_link_if.sv
`default_nettype none
interface fhwr_link_if;
   logic cs_n;
   logic sck;
   logic reset_n;
   logic host_io3_o;
   logic host_io3_oe;
   logic dev_io3_o;
   logic dev_io3_oe;
   logic shared_pin_a;

   // pull-up wins when nobody drives
   assign shared_pin_a = dev_io3_oe ? dev_io3_o : (host_io3_oe ? host_io3_o : 1'b1);

   modport dev (
      input  cs_n,
      input  sck,
      input  reset_n,
      input  shared_pin_a,
      output dev_io3_o,
      output dev_io3_oe
   );

   modport host (
      output cs_n,
      output sck,
      output reset_n,
      output host_io3_o,
      output host_io3_oe,
      input  shared_pin_a
   );
endinterface
`default_nettype wire

// ### fhwr_low_qual.sv
`include "fhwr_map.svh"
`default_nettype none
module fhwr_low_qual
   import fhwr_pkg::*;
#(
   parameter int unsigned CNT_W   = 8,
   parameter int unsigned MIN_CYC = `FHWR_RP_CYC
) (
   // system
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // pin and qualifier
   input  wire logic pin_raw,
   input  wire logic gate,
   // results
   output logic      level_sync,
   output logic      fire
);
   logic             meta_reg;
   logic             meta_next;
   logic             sync_reg;
   logic             sync_next;
   logic             armed_reg;
   logic             armed_next;
   logic             fire_reg;
   logic             fire_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;

   always_comb begin
      meta_next  = pin_raw;
      sync_next  = meta_reg;
      armed_next = armed_reg;
      cnt_next   = cnt_reg;
      fire_next  = 1'b0;
      if (sync_reg) begin
         // only a high-to-low edge can start a reset
         armed_next = 1'b1;
         cnt_next   = '0;
      end else if (!gate || !armed_reg) begin
         cnt_next = '0;
      end else if (cnt_reg == CNT_W'(MIN_CYC)) begin
         fire_next  = 1'b1;
         armed_next = 1'b0;
         cnt_next   = '0;
      end else begin
         cnt_next = cnt_reg + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_reg  <= 1'b1;
         sync_reg  <= 1'b1;
         armed_reg <= 1'b0;
         fire_reg  <= 1'b0;
         cnt_reg   <= '0;
      end else begin
         meta_reg  <= meta_next;
         sync_reg  <= sync_next;
         armed_reg <= armed_next;
         fire_reg  <= fire_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign level_sync = sync_reg;
   assign fire       = fire_reg;
endmodule // fhwr_low_qual
`default_nettype wire

// ### fhwr_device.sv
`include "fhwr_map.svh"
`default_nettype none
module fhwr_device
   import fhwr_pkg::*;
#(
   parameter int unsigned PU_CYC = `FHWR_PU_CYC_DEF,
   parameter int unsigned CNT_W  = 16
) (
   // system
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // link
   fhwr_link_if.dev  link,
   // configuration
   input  wire logic quad_enable_volatile,
   input  wire logic shared_pin_reset_enable,
   input  wire logic por_fault,
   // core side
   input  wire logic sw_reset_cmd,
   input  wire logic quad_read_active,
   input  wire logic io3_data,
   // status
   output logic      reg_restore,
   output logic      abort_op,
   output logic      full_por_run,
   output logic      in_reset,
   output logic      outputs_hiz,
   output logic      select_ok,
   output logic      cmd_accept
);
   // warm count starts at detection, so the qualify time is taken off
   localparam int unsigned WARM_CYC = `FHWR_RPH_CYC - `FHWR_RP_CYC - 1;

   function automatic logic dev_busy(input fhwr_dev_state_e st);
      dev_busy = (st != FHWR_D_IDLE);
   endfunction

   // select synchroniser and deselect timer
   logic             cs_meta_reg;
   logic             cs_meta_next;
   logic             cs_sync_reg;
   logic             cs_sync_next;
   logic             cs_prev_reg;
   logic             cs_prev_next;
   logic [3:0]       cs_hi_cnt_reg;
   logic [3:0]       cs_hi_cnt_next;

   always_comb begin
      cs_meta_next   = link.cs_n;
      cs_sync_next   = cs_meta_reg;
      cs_prev_next   = cs_sync_reg;
      cs_hi_cnt_next = cs_hi_cnt_reg;
      if (!cs_sync_reg) begin
         cs_hi_cnt_next = '0;
      end else if (cs_hi_cnt_reg != 4'hf) begin
         cs_hi_cnt_next = cs_hi_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cs_meta_reg   <= 1'b1;
         cs_sync_reg   <= 1'b1;
         cs_prev_reg   <= 1'b1;
         cs_hi_cnt_reg <= '0;
      end else begin
         cs_meta_reg   <= cs_meta_next;
         cs_sync_reg   <= cs_sync_next;
         cs_prev_reg   <= cs_prev_next;
         cs_hi_cnt_reg <= cs_hi_cnt_next;
      end
   end

   // shared pin counts as reset when quad is off, or when enabled and deselected long enough
   logic shared_gate;
   always_comb begin
      shared_gate = !quad_enable_volatile
                    || (shared_pin_reset_enable && cs_sync_reg
                        && (cs_hi_cnt_reg >= 4'(`FHWR_CS_CYC)));
   end

   // reset pulse qualifiers: bit 0 dedicated pin, bit 1 shared pin
   logic [1:0] pin_raw;
   logic [1:0] gate;
   logic [1:0] lvl;
   logic [1:0] fire;

   assign pin_raw = {link.shared_pin_a, link.reset_n};
   assign gate    = {shared_gate, 1'b1};

   for (genvar i = 0; i < 2; i++) begin : g_qual
      fhwr_low_qual #(
         .CNT_W   (8),
         .MIN_CYC (`FHWR_RP_CYC)
      ) u_qual (
         .clk_sys    (clk_sys),
         .rst_n      (rst_n),
         .pin_raw    (pin_raw[i]),
         .gate       (gate[i]),
         .level_sync (lvl[i]),
         .fire       (fire[i])
      );
   end

   logic pin_low_any;
   assign pin_low_any = !lvl[0] || (!lvl[1] && gate[1]);

   // reset sequencer
   fhwr_dev_state_e  state_reg;
   fhwr_dev_state_e  state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             restore_reg;
   logic             restore_next;
   logic             abort_reg;
   logic             abort_next;

   always_comb begin
      state_next   = state_reg;
      cnt_next     = cnt_reg + CNT_W'(1);
      restore_next = 1'b0;
      abort_next   = 1'b0;
      case (state_reg)
         FHWR_D_POWERUP: begin
            // pulses during power-up are dropped
            if (cnt_reg == CNT_W'(PU_CYC - 1)) begin
               cnt_next   = '0;
               state_next = pin_low_any ? FHWR_D_HELD : FHWR_D_IDLE;
            end
         end
         FHWR_D_IDLE: begin
            cnt_next = '0;
            if (|fire) begin
               abort_next   = 1'b1;
               restore_next = 1'b1;
               state_next   = por_fault ? FHWR_D_FULLPOR : FHWR_D_WARM;
            end else if (sw_reset_cmd) begin
               // pin level plays no part here
               abort_next   = 1'b1;
               restore_next = 1'b1;
            end
         end
         FHWR_D_WARM: begin
            if (cnt_reg == CNT_W'(WARM_CYC - 1)) begin
               cnt_next   = '0;
               state_next = pin_low_any ? FHWR_D_HELD : FHWR_D_IDLE;
            end
         end
         FHWR_D_FULLPOR: begin
            if (cnt_reg == CNT_W'(PU_CYC - 1)) begin
               cnt_next   = '0;
               state_next = pin_low_any ? FHWR_D_HELD : FHWR_D_IDLE;
            end
         end
         FHWR_D_HELD: begin
            cnt_next = '0;
            if (!pin_low_any) begin
               state_next = FHWR_D_HOLD;
            end
         end
         FHWR_D_HOLD: begin
            // selection waits out the hold time after release
            if (pin_low_any) begin
               cnt_next   = '0;
               state_next = FHWR_D_HELD;
            end else if (cnt_reg == CNT_W'(`FHWR_RH_CYC - 1)) begin
               cnt_next   = '0;
               state_next = FHWR_D_IDLE;
            end
         end
         default: begin
            cnt_next   = '0;
            state_next = FHWR_D_POWERUP;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg   <= FHWR_D_POWERUP;
         cnt_reg     <= '0;
         restore_reg <= 1'b0;
         abort_reg   <= 1'b0;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         restore_reg <= restore_next;
         abort_reg   <= abort_next;
      end
   end

   // io3 drive: data during quad read, then a short high tail
   logic       io3_o_reg;
   logic       io3_o_next;
   logic       io3_oe_reg;
   logic       io3_oe_next;
   logic       qrd_seen_reg;
   logic       qrd_seen_next;
   logic [3:0] tail_reg;
   logic [3:0] tail_next;

   always_comb begin
      qrd_seen_next = qrd_seen_reg;
      tail_next     = tail_reg;
      io3_o_next    = 1'b1;
      io3_oe_next   = 1'b0;
      if (dev_busy(state_next) || dev_busy(state_reg)) begin
         qrd_seen_next = 1'b0;
         tail_next     = '0;
      end else if (!cs_sync_reg && quad_read_active) begin
         qrd_seen_next = 1'b1;
         io3_o_next    = io3_data;
         io3_oe_next   = 1'b1;
      end else if (cs_sync_reg && !cs_prev_reg && qrd_seen_reg) begin
         // park the line high so the pull-up is not trusted to win
         qrd_seen_next = 1'b0;
         tail_next     = 4'(`FHWR_DIS_CYC - 1);
         io3_oe_next   = 1'b1;
      end else if (tail_reg != 4'h0) begin
         tail_next   = tail_reg - 4'h1;
         io3_oe_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         io3_o_reg    <= 1'b1;
         io3_oe_reg   <= 1'b0;
         qrd_seen_reg <= 1'b0;
         tail_reg     <= '0;
      end else begin
         io3_o_reg    <= io3_o_next;
         io3_oe_reg   <= io3_oe_next;
         qrd_seen_reg <= qrd_seen_next;
         tail_reg     <= tail_next;
      end
   end

   assign link.dev_io3_o  = io3_o_reg;
   assign link.dev_io3_oe = io3_oe_reg;

   assign reg_restore  = restore_reg;
   assign abort_op     = abort_reg;
   assign full_por_run = (state_reg == FHWR_D_FULLPOR) || (state_reg == FHWR_D_POWERUP);
   assign in_reset     = dev_busy(state_reg);
   assign outputs_hiz  = dev_busy(state_reg);
   assign select_ok    = !dev_busy(state_reg);
   assign cmd_accept   = !dev_busy(state_reg) && !cs_sync_reg;
endmodule // fhwr_device
`default_nettype wire

// ### fhwr_host.sv
`include "fhwr_map.svh"
`default_nettype none
module fhwr_host
   import fhwr_pkg::*;
#(
   parameter int unsigned SCK_HALF = `FHWR_SCK_HALF_DEF
) (
   // system
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // link
   fhwr_link_if.host link,
   // user requests
   input  wire logic hw_reset_req,
   input  wire logic use_shared_pin,
   input  wire logic boot_autoread,
   input  wire logic xfer_cs_req,
   input  wire logic io3_wr_active,
   input  wire logic io3_wr_data,
   // status
   output logic      reset_busy,
   output logic      xfer_granted
);
   localparam int unsigned PULSE_AB = `FHWR_RP_CYC + `FHWR_PULSE_MARGIN;
   localparam int unsigned HOLD_AB  = `FHWR_RPH_CYC - PULSE_AB + `FHWR_PULSE_MARGIN;
   localparam int unsigned HOLD_STD = `FHWR_RH_CYC + `FHWR_PULSE_MARGIN;

   fhwr_host_state_e state_reg;
   fhwr_host_state_e state_next;
   fhwr_cnt_t        cnt_reg;
   fhwr_cnt_t        cnt_next;
   fhwr_cnt_t        len_reg;
   fhwr_cnt_t        len_next;
   logic             shared_reg;
   logic             shared_next;
   logic             ab_reg;
   logic             ab_next;

   always_comb begin
      state_next  = state_reg;
      cnt_next    = cnt_reg + 16'h0001;
      len_next    = len_reg;
      shared_next = shared_reg;
      ab_next     = ab_reg;
      case (state_reg)
         FHWR_H_IDLE: begin
            cnt_next = '0;
            if (hw_reset_req) begin
               shared_next = use_shared_pin;
               ab_next     = boot_autoread;
               // short pulse under autoread, else the whole recovery
               len_next    = boot_autoread ? 16'(PULSE_AB - 1)
                                           : 16'(`FHWR_RPH_CYC - 1);
               state_next  = FHWR_H_PULSE;
            end
         end
         FHWR_H_PULSE: begin
            if (cnt_reg == len_reg) begin
               cnt_next   = '0;
               len_next   = ab_reg ? 16'(HOLD_AB - 1) : 16'(HOLD_STD - 1);
               state_next = FHWR_H_HOLD;
            end
         end
         FHWR_H_HOLD: begin
            if (cnt_reg == len_reg) begin
               cnt_next   = '0;
               state_next = FHWR_H_SETUP;
            end
         end
         FHWR_H_SETUP: begin
            // new reset requests are dropped here
            if (cnt_reg == 16'(`FHWR_RS_CYC - 1)) begin
               cnt_next   = '0;
               state_next = FHWR_H_IDLE;
            end
         end
         default: begin
            cnt_next   = '0;
            state_next = FHWR_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg  <= FHWR_H_IDLE;
         cnt_reg    <= '0;
         len_reg    <= '0;
         shared_reg <= 1'b0;
         ab_reg     <= 1'b0;
      end else begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         len_reg    <= len_next;
         shared_reg <= shared_next;
         ab_reg     <= ab_next;
      end
   end

   // pins: select, clock divider, reset and io3 drive
   logic       cs_n_reg;
   logic       cs_n_next;
   logic       rst_pin_reg;
   logic       rst_pin_next;
   logic       sck_reg;
   logic       sck_next;
   logic [7:0] div_reg;
   logic [7:0] div_next;
   logic       io3_o_reg;
   logic       io3_o_next;
   logic       io3_oe_reg;
   logic       io3_oe_next;
   logic       wr_prev_reg;
   logic       wr_prev_next;
   logic       in_rst;

   always_comb begin
      in_rst       = (state_next == FHWR_H_PULSE) || (state_next == FHWR_H_HOLD);
      cs_n_next    = !(xfer_cs_req && !in_rst);
      rst_pin_next = !((state_next == FHWR_H_PULSE) && !shared_next);
      wr_prev_next = io3_wr_active && !cs_n_reg;
      div_next     = div_reg;
      sck_next     = 1'b0;
      if (!cs_n_reg) begin
         sck_next = sck_reg;
         if (div_reg == 8'(SCK_HALF - 1)) begin
            div_next = '0;
            sck_next = !sck_reg;
         end else begin
            div_next = div_reg + 8'h01;
         end
      end else begin
         div_next = '0;
      end
      io3_o_next  = 1'b1;
      io3_oe_next = 1'b0;
      if ((state_next == FHWR_H_PULSE) && shared_next) begin
         io3_o_next  = 1'b0;
         io3_oe_next = 1'b1;
      end else if (io3_wr_active && !cs_n_reg) begin
         io3_o_next  = io3_wr_data;
         io3_oe_next = 1'b1;
      end else if (wr_prev_reg || ((state_reg == FHWR_H_PULSE) && shared_reg)) begin
         // one high cycle before letting go
         io3_oe_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cs_n_reg    <= 1'b1;
         rst_pin_reg <= 1'b1;
         sck_reg     <= 1'b0;
         div_reg     <= '0;
         io3_o_reg   <= 1'b1;
         io3_oe_reg  <= 1'b0;
         wr_prev_reg <= 1'b0;
      end else begin
         cs_n_reg    <= cs_n_next;
         rst_pin_reg <= rst_pin_next;
         sck_reg     <= sck_next;
         div_reg     <= div_next;
         io3_o_reg   <= io3_o_next;
         io3_oe_reg  <= io3_oe_next;
         wr_prev_reg <= wr_prev_next;
      end
   end

   assign link.cs_n        = cs_n_reg;
   assign link.sck         = sck_reg;
   assign link.reset_n     = rst_pin_reg;
   assign link.host_io3_o  = io3_o_reg;
   assign link.host_io3_oe = io3_oe_reg;
   assign reset_busy       = (state_reg != FHWR_H_IDLE);
   assign xfer_granted     = !cs_n_reg;
endmodule // fhwr_host
`default_nettype wire

// ### fhwr_link_monitor.sv
`include "fhwr_map.svh"
`default_nettype none
module fhwr_link_monitor (
   // system
   input wire logic clk_sys,
   input wire logic rst_n,
   // link
   input wire logic cs_n,
   input wire logic sck,
   input wire logic reset_n,
   input wire logic host_io3_o,
   input wire logic host_io3_oe,
   input wire logic dev_io3_o,
   input wire logic dev_io3_oe,
   input wire logic shared_pin_a
);
   localparam logic [15:0] RPH_CNT = 16'(`FHWR_RPH_CYC);
   localparam logic [15:0] RP_CNT  = 16'(`FHWR_RP_CYC);

   logic [15:0] since_reg;
   logic [15:0] since_next;
   logic [15:0] low_reg;
   logic [15:0] low_next;
   logic        pin_q_reg;
   logic        pin_q_next;

   // saturates so a late select never wraps into a false fail
   always_comb begin
      pin_q_next = reset_n;
      since_next = since_reg + {15'h0000, since_reg != 16'hffff};
      if (!reset_n && pin_q_reg) begin
         since_next = 16'h0001;
      end
      low_next = reset_n ? 16'h0000 : low_reg + 16'h0001;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         since_reg <= 16'hffff;
         low_reg   <= 16'h0000;
         pin_q_reg <= 1'b1;
      end else begin
         since_reg <= since_next;
         low_reg   <= low_next;
         pin_q_reg <= pin_q_next;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_high_run;
      reset_n [*3];
   endsequence

   sequence s_held_high;
      $past(reset_n, 1) && $past(reset_n, 2) && $past(reset_n, 3);
   endsequence

   chk_select_after_recovery: assert property ($fell(cs_n) |-> since_reg >= RPH_CNT)
      else $error("select too soon after reset fall");
   chk_setup_high_run: assert property ($rose(reset_n) |-> s_high_run)
      else $error("reset pin not high for setup time");
   chk_pulse_min_width: assert property ($rose(reset_n) |-> low_reg > RP_CNT)
      else $error("reset pulse shorter than minimum");
   chk_hold_before_select: assert property ($fell(cs_n) |-> s_held_high)
      else $error("select before reset hold time");
   chk_select_high_reset: assert property (!reset_n |-> cs_n)
      else $error("select low while reset low");
   chk_host_io3_release: assert property ($fell(host_io3_oe) |-> $past(host_io3_o))
      else $error("host released io3 without driving high");
   chk_dev_io3_release: assert property (
      $fell(dev_io3_oe) && $past(reset_n) |-> $past(dev_io3_o))
      else $error("device released io3 without driving high");
   chk_sck_idle_low: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> !sck)
      else $error("link clock runs while deselected");
endmodule // fhwr_link_monitor
`default_nettype wire

// ### testbench.sv
`include "fhwr_map.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PU  = 50;
   localparam int RP  = `FHWR_RP_CYC;
   localparam int RPH = `FHWR_RPH_CYC;
   localparam int RH  = `FHWR_RH_CYC;
   localparam int RPM = `FHWR_RP_MAX_CYC;

   logic clk_sys = 1'b0;
   logic rst_n   = 1'b0;
   logic quad_enable_volatile, shared_pin_reset_enable, por_fault, sw_reset_cmd;
   logic quad_read_active, io3_data, hw_reset_req, use_shared_pin, boot_autoread;
   logic xfer_cs_req, io3_wr_active, io3_wr_data;
   logic reg_restore, abort_op, full_por_run, in_reset, outputs_hiz, select_ok, cmd_accept;
   logic reset_busy, xfer_granted, b_abort;
   int   n_mismatch = 0;
   int   tests_run  = 0;
   int   n_abort    = 0;
   int   n_babort   = 0;
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (abort_op === 1'b1) n_abort++;
      if (b_abort === 1'b1) n_babort++;
   end

   fhwr_link_if link ();
   // second link: bench drives its pins
   fhwr_link_if link_b ();
   fhwr_device #(.PU_CYC(PU)) fhwr_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
      .quad_enable_volatile(quad_enable_volatile), .por_fault(por_fault),
      .shared_pin_reset_enable(shared_pin_reset_enable), .sw_reset_cmd(sw_reset_cmd),
      .quad_read_active(quad_read_active), .io3_data(io3_data), .reg_restore(reg_restore),
      .abort_op(abort_op), .full_por_run(full_por_run), .in_reset(in_reset),
      .outputs_hiz(outputs_hiz), .select_ok(select_ok), .cmd_accept(cmd_accept));
   fhwr_device #(.PU_CYC(PU)) fhwr_device_b_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_b),
      .quad_enable_volatile(quad_enable_volatile), .por_fault(por_fault),
      .shared_pin_reset_enable(shared_pin_reset_enable), .sw_reset_cmd(sw_reset_cmd),
      .quad_read_active(quad_read_active), .io3_data(io3_data), .reg_restore(), .abort_op(b_abort),
      .full_por_run(), .in_reset(), .outputs_hiz(), .select_ok(), .cmd_accept());
   fhwr_host fhwr_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
      .hw_reset_req(hw_reset_req), .use_shared_pin(use_shared_pin), .boot_autoread(boot_autoread),
      .xfer_cs_req(xfer_cs_req), .io3_wr_active(io3_wr_active), .io3_wr_data(io3_wr_data),
      .reset_busy(reset_busy), .xfer_granted(xfer_granted));
   fhwr_link_monitor fhwr_link_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .cs_n(link.cs_n), .sck(link.sck), .reset_n(link.reset_n), .host_io3_o(link.host_io3_o),
      .host_io3_oe(link.host_io3_oe), .dev_io3_o(link.dev_io3_o),
      .dev_io3_oe(link.dev_io3_oe), .shared_pin_a(link.shared_pin_a));

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic tmo(input int k, input int n);
      if (k >= n) begin
         check(1'b0, "wait ran out");
         conclude();
      end
   endtask

   task automatic pulse_req();
      hw_reset_req = 1'b1;
      cyc(1);
      hw_reset_req = 1'b0;
   endtask

   task automatic wait_idle();
      int k;
      for (k = 0; k < 6000 && (reset_busy !== 1'b0 || in_reset !== 1'b0); k++) cyc(1);
      tmo(k, 6000);
      cyc(5);
   endtask

   task automatic t_powerup();
      int k;
      pulse_req();
      cyc(PU + 20);
      check(in_reset & (n_abort == 0), "reset during power-up");
      for (k = 0; k < 3000 && link.reset_n !== 1'b1; k++) cyc(1);
      tmo(k, 3000);
      for (k = 0; k < 50 && select_ok !== 1'b1; k++) cyc(1);
      tmo(k, 50);
      check(k >= RH && n_abort == 0, "hold after held reset");
      wait_idle();
      $display("power-up test done");
   endtask

   task automatic t_warm();
      int k, a;
      xfer_cs_req = 1'b1;
      for (k = 0; k < 100 && xfer_granted !== 1'b1; k++) cyc(1);
      tmo(k, 100);
      a = n_abort;
      pulse_req();
      for (k = 0; k < 10 && link.reset_n !== 1'b0; k++) cyc(1);
      tmo(k, 10);
      for (k = 0; k < 40 && abort_op !== 1'b1; k++) cyc(1);
      tmo(k, 40);
      check(k > RP && k <= RP + 6, "qualify delay");
      check(reg_restore, "restore pulse");
      check(outputs_hiz & ~cmd_accept & ~xfer_granted, "recovery state");
      for (; k < 4000 && in_reset !== 1'b0; k++) cyc(1);
      tmo(k, 4000);
      check(k >= RPH && n_abort == a + 1, "recovery length");
      xfer_cs_req = 1'b0;
      wait_idle();
      $display("warm reset test done");
   endtask

   task automatic t_fullpor();
      int k;
      por_fault = 1'b1;
      pulse_req();
      for (k = 0; k < 60 && abort_op !== 1'b1; k++) cyc(1);
      tmo(k, 60);
      cyc(2);
      check(full_por_run, "full power-on run");
      wait_idle();
      por_fault = 1'b0;
      $display("full power-on test done");
   endtask

   task automatic t_sw();
      int a;
      a = n_abort;
      sw_reset_cmd = 1'b1;
      cyc(1);
      sw_reset_cmd = 1'b0;
      cyc(5);
      check(n_abort == a + 1 && in_reset === 1'b0, "software reset");
      $display("software reset test done");
   endtask

   task automatic t_boot_autoread();
      int k, w;
      boot_autoread = 1'b1;
      pulse_req();
      for (k = 0; k < 10 && link.reset_n !== 1'b0; k++) cyc(1);
      tmo(k, 10);
      for (w = 0; w < 400 && link.reset_n !== 1'b1; w++) cyc(1);
      tmo(w, 400);
      check(w > RP && w <= RPM, "autoread pulse width");
      wait_idle();
      boot_autoread = 1'b0;
      $display("autoread test done");
   endtask

   task automatic t_shared();
      logic [1:0] cfg [3] = '{2'b00, 2'b11, 2'b10};
      int         k, a, i;
      use_shared_pin = 1'b1;
      for (i = 0; i < 3; i++) begin
         {quad_enable_volatile, shared_pin_reset_enable} = cfg[i];
         a = n_abort;
         pulse_req();
         for (k = 0; k < 4000 && reset_busy !== 1'b0; k++) cyc(1);
         tmo(k, 4000);
         check(n_abort == a + int'(!cfg[i][1] || cfg[i][0]), "shared pin qualify");
         wait_idle();
      end
      use_shared_pin = 1'b0;
      $display("shared pin test done");
   endtask

   task automatic t_io3();
      int k, a;
      a = n_abort;
      {quad_enable_volatile, shared_pin_reset_enable} = 2'b11;
      xfer_cs_req = 1'b1;
      for (k = 0; k < 100 && xfer_granted !== 1'b1; k++) cyc(1);
      tmo(k, 100);
      {io3_wr_active, io3_wr_data} = 2'b10;
      cyc(20);
      check(link.shared_pin_a === 1'b0, "host drives io3 data");
      io3_wr_active = 1'b0;
      cyc(3);
      {quad_read_active, io3_data} = 2'b10;
      cyc(20);
      check(~link.shared_pin_a & link.dev_io3_oe, "device drives io3 data");
      xfer_cs_req = 1'b0;
      cyc(3);
      quad_read_active = 1'b0;
      cyc(10);
      check(link.shared_pin_a & (n_abort == a), "io3 low in transfer ignored");
      $display("io3 hand-off test done");
   endtask

   task automatic t_farside();
      int a;
      a = n_babort;
      link_b.reset_n = 1'b0;
      cyc(RP);
      link_b.reset_n = 1'b1;
      cyc(20);
      check(n_babort == a, "short pulse ignored");
      link_b.reset_n = 1'b0;
      cyc(RP + 4);
      link_b.reset_n = 1'b1;
      cyc(20);
      check(n_babort == a + 1, "long pulse fires");
      $display("far side pulse test done");
   endtask

   initial begin
      {quad_enable_volatile, shared_pin_reset_enable, por_fault, sw_reset_cmd} = 4'h0;
      {quad_read_active, io3_data, hw_reset_req, use_shared_pin, boot_autoread} = 5'h00;
      {xfer_cs_req, io3_wr_active, io3_wr_data} = 3'h0;
      {link_b.cs_n, link_b.sck, link_b.reset_n, link_b.host_io3_o, link_b.host_io3_oe} = 5'h16;
      cyc(12);
      rst_n = 1'b1;
      t_powerup();
      t_warm();
      t_fullpor();
      t_sw();
      t_boot_autoread();
      t_shared();
      t_io3();
      t_farside();
      conclude();
   end
endmodule // testbench
`default_nettype wire
